// ### include/serial_pkg.sv
// shared constants, types and helpers of the asynchronous serial port
package serial_pkg;
	// register offsets
	localparam logic [2:0] OFF_DATA = 3'h0;
	localparam logic [2:0] OFF_CTRL = 3'h1;
	localparam logic [2:0] OFF_FMT  = 3'h2;
	localparam logic [2:0] OFF_BGC  = 3'h3;
	localparam logic [2:0] OFF_RLH  = 3'h4;
	localparam logic [2:0] OFF_RLL  = 3'h5;
	// serial_control_status bit positions
	localparam int CTRL_RX_READY = 0;
	localparam int CTRL_TX_DONE  = 1;
	localparam int CTRL_RBX      = 2;
	localparam int CTRL_TBX      = 3;
	localparam int CTRL_RX_EN    = 4;
	localparam int CTRL_IRQ_EN   = 5;
	localparam int CTRL_OVR      = 6;
	localparam int CTRL_PERR     = 7;
	// serial_format_control fields
	localparam int FMT_LEN_LSB   = 0;
	localparam int FMT_STOP2     = 2;
	localparam int FMT_XBE       = 3;
	localparam int FMT_PTYPE_LSB = 4;
	localparam int FMT_PE        = 6;
	localparam int FMT_MCE       = 7;
	// baud_gen_control fields
	localparam int BGC_PS_LSB = 0;
	localparam int BGC_SRC    = 5;
	localparam int BGC_EN     = 6;
	// reset values
	localparam logic [7:0]  FMT_RST    = 8'h03;
	localparam logic [7:0]  BGC_RST    = 8'h00;
	localparam logic [7:0]  RELOAD_RST = 8'h00;
	// prescaler select codes and their divide factors
	localparam logic [1:0] PS_DIV12 = 2'h0;
	localparam logic [1:0] PS_DIV4  = 2'h1;
	localparam logic [1:0] PS_DIV48 = 2'h2;
	localparam logic [1:0] PS_DIV1  = 2'h3;
	localparam logic [5:0] DIV_1    = 6'h01;
	localparam logic [5:0] DIV_4    = 6'h04;
	localparam logic [5:0] DIV_12   = 6'h0C;
	localparam logic [5:0] DIV_48   = 6'h30;
	localparam logic [15:0] TIMER_TOP = 16'hFFFF;
	// receive buffer: eight data bits plus the extra or stop bit
	localparam int FIFO_DEPTH = 3;
	localparam int FIFO_W     = 9;

	typedef enum logic [2:0] {
		FR_IDLE  = 3'b000,
		FR_START = 3'b001,
		FR_DATA  = 3'b010,
		FR_PAR   = 3'b011,
		FR_STOP1 = 3'b100,
		FR_STOP2 = 3'b101
	} frame_state_e;

	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic       we;
		logic       re;
	} reg_req_s;

	// parity types: 0 odd, 1 even, 2 mark, 3 space
	function automatic logic parity_bit(input logic [1:0] pt, input logic [7:0] d);
		unique case (pt)
			2'h0: parity_bit = ~^d;
			2'h1: parity_bit = ^d;
			2'h2: parity_bit = 1'b1;
			2'h3: parity_bit = 1'b0;
		endcase
	endfunction : parity_bit

	function automatic logic [7:0] data_mask(input logic [1:0] len);
		data_mask = 8'hFF >> (2'h3 - len);
	endfunction : data_mask
endpackage : serial_pkg

// ### core/baud_gen.sv
// prescaled 16-bit reload timer giving the serial half-bit overflow tick
`timescale 1ns/1ps
`default_nettype none
module baud_gen (
	input  wire logic        clock,   // core system clock
	input  wire logic        resetn,  // async reset, active low
	input  wire logic        ce,      // clock enable
	input  wire logic        enable,  // generator enable
	input  wire logic [1:0]  ps_sel,  // prescaler select code
	input  wire logic [15:0] reload,  // timer reload value
	output logic             ovf      // one-cycle overflow pulse
);
	typedef struct packed {
		logic [5:0]  pre;
		logic [15:0] timer;
	} baud_state_s;

	baud_state_s s_q;
	baud_state_s s_d;
	logic [5:0]  lim;
	logic        tick;

	// code 11 is divide by one
	always_comb begin
		unique case (ps_sel)
			serial_pkg::PS_DIV12: lim = serial_pkg::DIV_12 - 6'h01;
			serial_pkg::PS_DIV4:  lim = serial_pkg::DIV_4 - 6'h01;
			serial_pkg::PS_DIV48: lim = serial_pkg::DIV_48 - 6'h01;
			serial_pkg::PS_DIV1:  lim = serial_pkg::DIV_1 - 6'h01;
		endcase
	end

	always_comb begin
		s_d  = s_q;
		tick = 1'b0;
		ovf  = 1'b0;
		if (!enable) begin
			s_d.pre   = 6'h00;
			s_d.timer = reload;
		end else begin
			if (s_q.pre >= lim) begin
				s_d.pre = 6'h00;
				tick    = ce;
			end else begin
				s_d.pre = s_q.pre + 6'h01;
			end
			if (tick) begin
				if (s_q.timer == serial_pkg::TIMER_TOP) begin
					s_d.timer = reload;
					ovf       = 1'b1;
				end else begin
					s_d.timer = s_q.timer + 16'h0001;
				end
			end
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			s_q <= '0;
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	reload_after_ovf_a: assert property (@(posedge clock) disable iff (!resetn)
		ovf |=> s_q.timer == $past(reload)) else $error("timer not reloaded after overflow");
	count_up_a: assert property (@(posedge clock) disable iff (!resetn)
		(ce && enable && tick && s_q.timer != serial_pkg::TIMER_TOP)
		|=> s_q.timer == $past(s_q.timer) + 16'h0001) else $error("timer did not step by one");
	div1_every_cycle_a: assert property (@(posedge clock) disable iff (!resetn)
		(ce && enable && ps_sel == serial_pkg::PS_DIV1 && s_q.pre == 6'h00) |-> tick)
		else $error("divide by one prescaler missed a tick");
endmodule : baud_gen
`default_nettype wire

// ### core/rx_fifo.sv
// three-entry receive buffer holding data byte plus extra bit
`timescale 1ns/1ps
`default_nettype none
module rx_fifo (
	input  wire logic        clock,   // core system clock
	input  wire logic        resetn,  // async reset, active low
	input  wire logic        ce,      // clock enable
	input  wire logic        push,    // store an entry
	input  wire logic [8:0]  wdata,   // entry to store
	input  wire logic        pop,     // drop the oldest entry
	output logic      [8:0]  head,    // oldest entry
	output logic      [1:0]  count,   // entries held
	output logic             full,    // three entries held
	output logic             empty    // nothing held
);
	typedef struct packed {
		logic [serial_pkg::FIFO_DEPTH-1:0][serial_pkg::FIFO_W-1:0] mem;
		logic [1:0] cnt;
		logic [1:0] rd;
		logic [1:0] wr;
	} fifo_state_s;

	fifo_state_s s_q;
	fifo_state_s s_d;
	logic        do_push;
	logic        do_pop;

	assign full  = s_q.cnt == 2'(serial_pkg::FIFO_DEPTH);
	assign empty = s_q.cnt == 2'h0;
	assign count = s_q.cnt;
	assign head  = s_q.mem[s_q.rd];

	assign do_push = push && !full;
	assign do_pop  = pop && !empty;

	always_comb begin
		s_d = s_q;
		if (do_push) begin
			s_d.mem[s_q.wr] = wdata;
			s_d.wr = (s_q.wr == 2'h2) ? 2'h0 : s_q.wr + 2'h1;
		end
		if (do_pop) begin
			s_d.rd = (s_q.rd == 2'h2) ? 2'h0 : s_q.rd + 2'h1;
		end
		s_d.cnt = s_q.cnt + {1'b0, do_push} - {1'b0, do_pop};
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			s_q <= '0;
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	depth_bound_a: assert property (@(posedge clock) disable iff (!resetn)
		s_q.cnt <= 2'h3) else $error("receive buffer count above three");
	full_holds_a: assert property (@(posedge clock) disable iff (!resetn)
		(ce && full && push && !pop) |=> full && head == $past(head))
		else $error("push into full buffer changed contents");
endmodule : rx_fifo
`default_nettype wire

// ### core/async_serial_port.sv
// full-duplex asynchronous serial port with registers and baud generator
//
// Contract
// - transmitter and receiver run at once on separate lines.
// - receive buffer holds three bytes; one more is an overflow.
// - every data window write loads the transmit holding register.
// - data window read returns the oldest received byte, never transmit data.
// - with interrupts enabled, tx done or rx ready raises the request.
// - flags stay set until software clears them.
// - clearing rx ready is ignored while two or more bytes wait.
// - bit rate from 16-bit timer behind prescaler 1, 4, 12 or 48.
// - port runs only with the baud generator enabled.
// - baud control holds enable, clock source and prescaler select.
// - timer counts up per prescaled tick from the reload value.
// - rollover from all ones reloads the timer at once.
// - bit rate is clock over reload span, halved, over prescale.
// - low start, 5 to 8 bits lsb first, option bit, stop bits.
// - write starts sending; tx done sets at stop bit start.
// - store and flag only with space and high stop; no space is overrun, low stop drops.
// - parity mismatch sets a sticky error flag cleared by software.
`timescale 1ns/1ps
`default_nettype none
module async_serial_port (
	input  wire logic                 clock,    // core system clock, 40 MHz
	input  wire logic                 resetn,   // async reset, active low
	input  wire logic                 ce,       // clock enable, freezes all state
	input  wire serial_pkg::reg_req_s bus_req,  // register address, data, strobes
	output logic                [7:0] rdata,    // read data, cycle after read strobe
	input  wire logic                 rx_line,  // serial receive line
	output logic                      tx_line,  // serial transmit line
	output logic                      irq       // serial interrupt request
);
	typedef struct packed {
		logic                     rx_ready;
		logic                     tx_done;
		logic                     tbx;
		logic                     rx_en;
		logic                     irq_en;
		logic                     ovr;
		logic                     perr;
		logic [7:0]               fmt;
		logic [7:0]               bgc;
		logic [7:0]               rl_hi;
		logic [7:0]               rl_lo;
		serial_pkg::frame_state_e tx_st;
		logic [7:0]               tx_hold;
		logic                     tx_par;
		logic                     tx_pend;
		logic [7:0]               tx_shift;
		logic [2:0]               tx_bitn;
		logic                     tx_half;
		logic                     tx_line;
		serial_pkg::frame_state_e rx_st;
		logic                     rx_prev;
		logic                     rx_ph;
		logic [7:0]               rx_shift;
		logic [2:0]               rx_bitn;
		logic                     rx_xbit;
		logic                     rx_stopok;
		logic [7:0]               rdata;
		logic                     irq;
	} port_state_s;

	port_state_s s_q;
	port_state_s s_d;
	logic        ovf;
	logic        bgen;
	logic [1:0]  len;
	logic [2:0]  last_bit;
	logic        opt_bit;
	logic        stop2;
	logic [1:0]  ptype;
	logic        tx_bit_end;
	logic        rx_sample;
	logic [7:0]  rx_data;
	logic        rx_done;
	logic [8:0]  f_head;
	logic [1:0]  f_count;
	logic        f_full;
	logic        f_empty;
	logic        push;
	logic [8:0]  push_data;
	logic        pop;
	logic [7:0]  ctrl_view;

	assign bgen     = s_q.bgc[serial_pkg::BGC_EN];
	assign len      = s_q.fmt[serial_pkg::FMT_LEN_LSB +: 2];
	assign last_bit = {1'b0, len} + 3'h4;
	assign opt_bit  = s_q.fmt[serial_pkg::FMT_PE] | s_q.fmt[serial_pkg::FMT_XBE];
	// second stop bit only offered for six bits and up
	assign stop2    = s_q.fmt[serial_pkg::FMT_STOP2] && len != 2'h0;
	assign ptype    = s_q.fmt[serial_pkg::FMT_PTYPE_LSB +: 2];
	assign tx_bit_end = ovf && s_q.tx_half;
	assign rx_sample  = ovf && s_q.rx_ph;
	assign rx_data    = s_q.rx_shift >> (2'h3 - len);

	assign ctrl_view = {s_q.perr, s_q.ovr, s_q.irq_en, s_q.rx_en, s_q.tbx,
		f_head[8], s_q.tx_done, s_q.rx_ready};

	baud_gen u_baud (
		.clock  (clock),
		.resetn (resetn),
		.ce     (ce),
		.enable (bgen),
		.ps_sel (s_q.bgc[serial_pkg::BGC_PS_LSB +: 2]),
		.reload ({s_q.rl_hi, s_q.rl_lo}),
		.ovf    (ovf)
	);

	rx_fifo u_fifo (
		.clock  (clock),
		.resetn (resetn),
		.ce     (ce),
		.push   (push),
		.wdata  (push_data),
		.pop    (pop),
		.head   (f_head),
		.count  (f_count),
		.full   (f_full),
		.empty  (f_empty)
	);

	always_comb begin
		s_d       = s_q;
		push      = 1'b0;
		push_data = 9'h000;
		pop       = 1'b0;
		s_d.rdata = 8'h00;

		// software clears go first so hardware sets below win
		if (bus_req.we) begin
			unique case (bus_req.addr)
				serial_pkg::OFF_DATA: begin
					s_d.tx_hold = bus_req.wdata;
					s_d.tx_pend = 1'b1;
				end
				serial_pkg::OFF_CTRL: begin
					// keep rx ready while two or more bytes wait
					if (!bus_req.wdata[serial_pkg::CTRL_RX_READY] && f_count <= 2'h1)
						s_d.rx_ready = 1'b0;
					if (!bus_req.wdata[serial_pkg::CTRL_TX_DONE])
						s_d.tx_done = 1'b0;
					if (!bus_req.wdata[serial_pkg::CTRL_OVR])
						s_d.ovr = 1'b0;
					if (!bus_req.wdata[serial_pkg::CTRL_PERR])
						s_d.perr = 1'b0;
					s_d.tbx    = bus_req.wdata[serial_pkg::CTRL_TBX];
					s_d.rx_en  = bus_req.wdata[serial_pkg::CTRL_RX_EN];
					s_d.irq_en = bus_req.wdata[serial_pkg::CTRL_IRQ_EN];
				end
				serial_pkg::OFF_FMT: s_d.fmt   = bus_req.wdata;
				serial_pkg::OFF_BGC: s_d.bgc   = bus_req.wdata;
				serial_pkg::OFF_RLH: s_d.rl_hi = bus_req.wdata;
				serial_pkg::OFF_RLL: s_d.rl_lo = bus_req.wdata;
				default: ;
			endcase
		end
		if (bus_req.re) begin
			unique case (bus_req.addr)
				serial_pkg::OFF_DATA: begin
					s_d.rdata = f_empty ? 8'h00 : f_head[7:0];
					pop       = 1'b1;
				end
				serial_pkg::OFF_CTRL: s_d.rdata = ctrl_view;
				serial_pkg::OFF_FMT:  s_d.rdata = s_q.fmt;
				serial_pkg::OFF_BGC:  s_d.rdata = s_q.bgc;
				serial_pkg::OFF_RLH:  s_d.rdata = s_q.rl_hi;
				serial_pkg::OFF_RLL:  s_d.rdata = s_q.rl_lo;
				default:              s_d.rdata = 8'h00;
			endcase
		end

		// transmitter
		if (ovf)
			s_d.tx_half = ~s_q.tx_half;
		if (!bgen) begin
			s_d.tx_st   = serial_pkg::FR_IDLE;
			s_d.tx_line = 1'b1;
		end else begin
			unique case (s_q.tx_st)
				serial_pkg::FR_IDLE: begin
					s_d.tx_line = 1'b1;
					// start on pending write, aligned to a baud overflow
					// low start bit, so every bit lasts two full overflows
					if (s_q.tx_pend && ovf) begin
						s_d.tx_st    = serial_pkg::FR_START;
						s_d.tx_shift = s_q.tx_hold;
						s_d.tx_par   = serial_pkg::parity_bit(ptype,
							s_q.tx_hold & serial_pkg::data_mask(len));
						s_d.tx_pend  = bus_req.we && bus_req.addr == serial_pkg::OFF_DATA;
						s_d.tx_half  = 1'b0;
						s_d.tx_bitn  = 3'h0;
						s_d.tx_line  = 1'b0;
					end
				end
				serial_pkg::FR_START: if (tx_bit_end) begin
					s_d.tx_st   = serial_pkg::FR_DATA;
					s_d.tx_line = s_q.tx_shift[0];
				end
				serial_pkg::FR_DATA: if (tx_bit_end) begin
					if (s_q.tx_bitn == last_bit) begin
						if (opt_bit) begin
							s_d.tx_st   = serial_pkg::FR_PAR;
							s_d.tx_line = s_q.fmt[serial_pkg::FMT_PE] ? s_q.tx_par : s_q.tbx;
						end else begin
							s_d.tx_st   = serial_pkg::FR_STOP1;
							s_d.tx_line = 1'b1;
						end
					end else begin
						s_d.tx_bitn  = s_q.tx_bitn + 3'h1;
						s_d.tx_shift = s_q.tx_shift >> 1;
						s_d.tx_line  = s_q.tx_shift[1];
					end
				end
				serial_pkg::FR_PAR: if (tx_bit_end) begin
					s_d.tx_st   = serial_pkg::FR_STOP1;
					s_d.tx_line = 1'b1;
				end
				serial_pkg::FR_STOP1: if (tx_bit_end) begin
					s_d.tx_st = stop2 ? serial_pkg::FR_STOP2 : serial_pkg::FR_IDLE;
				end
				serial_pkg::FR_STOP2: if (tx_bit_end) begin
					s_d.tx_st = serial_pkg::FR_IDLE;
				end
				default: s_d.tx_st = serial_pkg::FR_IDLE;
			endcase
		end
		// done flag at stop bit start
		if (s_q.tx_st != serial_pkg::FR_STOP1 && s_d.tx_st == serial_pkg::FR_STOP1)
			s_d.tx_done = 1'b1;

		// receiver, independent of the transmitter
		// separate receive path
		s_d.rx_prev = rx_line;
		if (!bgen || !s_q.rx_en) begin
			s_d.rx_st = serial_pkg::FR_IDLE;
		end else begin
			if (ovf)
				s_d.rx_ph = ~s_q.rx_ph;
			unique case (s_q.rx_st)
				serial_pkg::FR_IDLE: if (s_q.rx_prev && !rx_line) begin
					s_d.rx_st     = serial_pkg::FR_START;
					s_d.rx_ph     = 1'b1;
					s_d.rx_bitn   = 3'h0;
					s_d.rx_stopok = 1'b1;
					s_d.rx_xbit   = 1'b0;
				end
				// start checked half a bit in, then sampled every bit
				serial_pkg::FR_START: if (rx_sample) begin
					s_d.rx_st = rx_line ? serial_pkg::FR_IDLE : serial_pkg::FR_DATA;
					s_d.rx_ph = 1'b0;
				end
				serial_pkg::FR_DATA: if (rx_sample) begin
					s_d.rx_shift = {rx_line, s_q.rx_shift[7:1]};
					if (s_q.rx_bitn == last_bit)
						s_d.rx_st = opt_bit ? serial_pkg::FR_PAR : serial_pkg::FR_STOP1;
					else
						s_d.rx_bitn = s_q.rx_bitn + 3'h1;
				end
				serial_pkg::FR_PAR: if (rx_sample) begin
					s_d.rx_xbit = rx_line;
					s_d.rx_st   = serial_pkg::FR_STOP1;
				end
				serial_pkg::FR_STOP1: if (rx_sample) begin
					s_d.rx_stopok = rx_line;
					s_d.rx_st     = stop2 ? serial_pkg::FR_STOP2 : serial_pkg::FR_IDLE;
				end
				serial_pkg::FR_STOP2: if (rx_sample) begin
					s_d.rx_stopok = s_q.rx_stopok & rx_line;
					s_d.rx_st     = serial_pkg::FR_IDLE;
				end
				default: s_d.rx_st = serial_pkg::FR_IDLE;
			endcase
		end
		rx_done = bgen && s_q.rx_en && rx_sample && (s_q.rx_st == serial_pkg::FR_STOP2 ||
			(s_q.rx_st == serial_pkg::FR_STOP1 && !stop2));
		if (rx_done) begin
			if (s_q.fmt[serial_pkg::FMT_PE] &&
				s_q.rx_xbit != serial_pkg::parity_bit(ptype, rx_data))
				s_d.perr = 1'b1;
			if (f_full) begin
				s_d.ovr = 1'b1;
			end else if (s_d.rx_stopok &&
				!(s_q.fmt[serial_pkg::FMT_MCE] && !s_q.rx_xbit)) begin
				push         = 1'b1;
				push_data    = {s_q.fmt[serial_pkg::FMT_XBE] && !s_q.fmt[serial_pkg::FMT_PE]
					? s_q.rx_xbit : s_d.rx_stopok, rx_data};
				s_d.rx_ready = 1'b1;
			end
		end

		s_d.irq = s_d.irq_en && (s_d.rx_ready || s_d.tx_done);
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			s_q         <= '0;
			s_q.fmt     <= serial_pkg::FMT_RST;
			s_q.bgc     <= serial_pkg::BGC_RST;
			s_q.rl_hi   <= serial_pkg::RELOAD_RST;
			s_q.rl_lo   <= serial_pkg::RELOAD_RST;
			s_q.tx_st   <= serial_pkg::FR_IDLE;
			s_q.rx_st   <= serial_pkg::FR_IDLE;
			s_q.tx_line <= 1'b1;
			s_q.rx_prev <= 1'b1;
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	assign rdata   = s_q.rdata;
	assign tx_line = s_q.tx_line;
	assign irq     = s_q.irq;

	idle_line_high_a: assert property (@(posedge clock) disable iff (!resetn)
		s_q.tx_st == serial_pkg::FR_IDLE |-> tx_line) else $error("transmit line low while idle");
	tx_done_at_stop_a: assert property (@(posedge clock) disable iff (!resetn)
		(s_q.tx_st == serial_pkg::FR_STOP1 && $past(s_q.tx_st) != serial_pkg::FR_STOP1)
		|-> s_q.tx_done && tx_line) else $error("tx done not set at stop bit start");
	write_to_hold_a: assert property (@(posedge clock) disable iff (!resetn)
		(ce && bus_req.we && bus_req.addr == serial_pkg::OFF_DATA)
		|=> s_q.tx_hold == $past(bus_req.wdata) && s_q.tx_pend)
		else $error("data window write missed holding register");
	read_gives_rx_a: assert property (@(posedge clock) disable iff (!resetn)
		(ce && bus_req.re && bus_req.addr == serial_pkg::OFF_DATA && !f_empty)
		|=> rdata == $past(f_head[7:0])) else $error("data window read not oldest byte");
	irq_follows_a: assert property (@(posedge clock) disable iff (!resetn)
		ce ##1 (s_q.irq_en && (s_q.rx_ready || s_q.tx_done)) |-> irq)
		else $error("interrupt request missing");
	rx_ready_kept_a: assert property (@(posedge clock) disable iff (!resetn)
		(ce && s_q.rx_ready && f_count > 2'h1) |=> s_q.rx_ready)
		else $error("rx ready cleared with bytes waiting");
	flag_sticky_a: assert property (@(posedge clock) disable iff (!resetn)
		(s_q.tx_done && !(bus_req.we && bus_req.addr == serial_pkg::OFF_CTRL)) |=> s_q.tx_done)
		else $error("tx done cleared without software");
	no_run_disabled_a: assert property (@(posedge clock) disable iff (!resetn)
		(ce && !bgen) |=> s_q.tx_st == serial_pkg::FR_IDLE && tx_line)
		else $error("transmitter ran with generator off");
	overrun_set_a: assert property (@(posedge clock) disable iff (!resetn)
		(ce && rx_done && f_full) |=> s_q.ovr) else $error("overrun not flagged");

	frame_sent_c: cover property (@(posedge clock) disable iff (!resetn)
		s_q.tx_st == serial_pkg::FR_STOP1 ##1 s_q.tx_st == serial_pkg::FR_IDLE);
	byte_stored_c: cover property (@(posedge clock) disable iff (!resetn) push);
	buffer_full_c: cover property (@(posedge clock) disable iff (!resetn) f_full ##1 s_q.ovr);
	parity_err_c: cover property (@(posedge clock) disable iff (!resetn)
		!s_q.perr ##1 s_q.perr);
endmodule : async_serial_port
`default_nettype wire

// ### bench/remote_serial_dev.sv
// remote serial device model: frame sender and byte listener
`timescale 1ns/1ps
`default_nettype none
module remote_serial_dev #(
	parameter int BIT_CLKS = 16  // clocks per bit
) (
	input  wire logic       clock,    // core clock
	input  wire logic       tx_line,  // line from the port
	output logic            rx_line,  // line to the port
	output logic      [7:0] got_byte  // last byte heard
);
	logic [7:0] sh;
	logic [10:0] f;
	initial rx_line = 1'b1;
	// slow enough rate, lsb first, optional bit, stop
	task automatic send(input logic [7:0] d, input logic pe, input logic pv, input logic sv);
		f = {sv, pv, d, 1'b0};
		for (int i = 0; i < 11; i++) begin
			if (i != 9 || pe) begin
				rx_line <= f[i];
				repeat (BIT_CLKS) @(posedge clock);
			end
		end
		rx_line <= 1'b1;
		@(posedge clock);
	endtask : send
	// start on falling edge, sample mid bit
	always @(negedge tx_line) begin
		repeat (BIT_CLKS / 2) @(posedge clock);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CLKS) @(posedge clock);
			sh[i] = tx_line;
		end
		got_byte = sh;
	end
endmodule : remote_serial_dev
`default_nettype wire

// ### bench/async_serial_port_tb.sv
// self-checking bench of the asynchronous serial port
`timescale 1ns/1ps
`default_nettype none
module async_serial_port_tb;
	logic                 clock, resetn, ce, rx_line, tx_line, irq;
	serial_pkg::reg_req_s bus_req;
	logic           [7:0] rdata, r, got;
	int                   error_cnt, checked, n;
	int                   divs [4];
	async_serial_port async_serial_port_inst (.clock(clock), .resetn(resetn), .ce(ce),
		.bus_req(bus_req), .rdata(rdata), .rx_line(rx_line), .tx_line(tx_line), .irq(irq));
	remote_serial_dev remote_serial_dev_inst (.clock(clock), .tx_line(tx_line),
		.rx_line(rx_line), .got_byte(got));
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	task automatic tick();
		@(posedge clock);
	endtask : tick
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		bus_req <= '{a, d, 1'b1, 1'b0};
		tick();
		bus_req <= '0;
		tick();
	endtask : wr
	task automatic rd(input logic [2:0] a);
		bus_req <= '{a, 8'h00, 1'b0, 1'b1};
		tick();
		bus_req <= '0;
		tick();
		r = rdata;
	endtask : rd
	task automatic chk8(input logic [7:0] g, input logic [7:0] e);
		checked++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %0t got %h expected %h", $time, g, e);
		end
	endtask : chk8
	task automatic chkn(input int g, input int e);
		checked++;
		if (g != e) begin
			error_cnt++;
			$display("[FAIL] %0t count %0d expected %0d", $time, g, e);
		end
	endtask : chkn
	task automatic wrap_up();
		if (error_cnt == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : wrap_up
	// long frames at /48 bound the run well below this
	initial begin
		repeat (60000) @(posedge clock);
		error_cnt++;
		wrap_up();
	end
	initial begin
		ce = 1'b1;
		bus_req = '0;
		resetn = 1'b0;
		error_cnt = 0;
		checked = 0;
		divs = '{12, 4, 48, 1};
		repeat (5) @(posedge clock);
		resetn <= 1'b1;
		tick();
		chk8({7'h00, tx_line}, 8'h01);
		wr(3'h7, 8'hFF);
		for (int a = 0; a < 8; a++) begin
			rd(3'(a));
			chk8(r, (a == 2) ? 8'h03 : 8'h00);
		end
		wr(serial_pkg::OFF_RLH, 8'hFF);
		wr(serial_pkg::OFF_RLL, 8'hF8);
		wr(serial_pkg::OFF_BGC, 8'h63);
		rd(serial_pkg::OFF_BGC);
		chk8(r, 8'h63);
		wr(serial_pkg::OFF_BGC, 8'h43);
		wr(serial_pkg::OFF_CTRL, 8'h20);
		wr(serial_pkg::OFF_DATA, 8'hA5);
		for (n = 0; n < 400 && irq !== 1'b1; n++) tick();
		chk8({7'h00, irq}, 8'h01);
		rd(serial_pkg::OFF_CTRL);
		chk8(r & 8'h02, 8'h02);
		repeat (20) tick();
		chk8(got, 8'hA5);
		wr(serial_pkg::OFF_CTRL, 8'h20);
		tick();
		chk8({7'h00, irq}, 8'h00);
		wr(serial_pkg::OFF_CTRL, 8'h10);
		fork
			for (int i = 0; i < 4; i++) remote_serial_dev_inst.send(8'h31 + 8'(i), 0, 0, 1);
			wr(serial_pkg::OFF_DATA, 8'h5C);
		join
		repeat (40) tick();
		chk8(got, 8'h5C);
		rd(serial_pkg::OFF_CTRL);
		chk8(r, 8'h57);
		wr(serial_pkg::OFF_CTRL, 8'h10);
		rd(serial_pkg::OFF_CTRL);
		chk8(r, 8'h15);
		rd(serial_pkg::OFF_DATA);
		chk8(r, 8'h31);
		rd(serial_pkg::OFF_DATA);
		chk8(r, 8'h32);
		wr(serial_pkg::OFF_CTRL, 8'h10);
		rd(serial_pkg::OFF_CTRL);
		chk8(r & 8'h01, 8'h00);
		rd(serial_pkg::OFF_DATA);
		chk8(r, 8'h33);
		rd(serial_pkg::OFF_DATA);
		chk8(r, 8'h00);
		remote_serial_dev_inst.send(8'h66, 0, 0, 0);
		repeat (40) tick();
		rd(serial_pkg::OFF_CTRL);
		chk8(r & 8'h01, 8'h00);
		wr(serial_pkg::OFF_FMT, 8'h43);
		remote_serial_dev_inst.send(8'h3C, 1, 0, 1);
		repeat (40) tick();
		rd(serial_pkg::OFF_CTRL);
		chk8(r & 8'h80, 8'h80);
		wr(serial_pkg::OFF_FMT, 8'h03);
		for (int c = 0; c < 4; c++) begin
			wr(serial_pkg::OFF_BGC, 8'h40 | 8'(c));
			wr(serial_pkg::OFF_DATA, 8'hFF);
			for (n = 0; n < 4000 && tx_line !== 1'b0; n++) tick();
			for (n = 0; n < 2000 && tx_line === 1'b0; n++) tick();
			chkn(n, 2 * divs[c] * 8);
			r = 8'h00;
			for (n = 0; n < 5000 && r[1] !== 1'b1; n++) rd(serial_pkg::OFF_CTRL);
			chk8(r & 8'h02, 8'h02);
			wr(serial_pkg::OFF_CTRL, 8'h10);
		end
		wr(serial_pkg::OFF_BGC, 8'h03);
		wr(serial_pkg::OFF_DATA, 8'h00);
		n = 0;
		repeat (200) begin
			tick();
			if (tx_line !== 1'b1) n++;
		end
		chkn(n, 0);
		wrap_up();
	end
endmodule : async_serial_port_tb
`default_nettype wire
